// ---- logic/feac_consts.svh ----
`ifndef FEAC_CONSTS_SVH
`define FEAC_CONSTS_SVH
`define FEAC_FLAG_BYTE     8'hFF
`define FEAC_CODE_W        6
`define FEAC_WORD_W        16
`define FEAC_REP_MIN       4'h3
`define FEAC_REP_MAX       4'hF
`define FEAC_CODE_DS3_SA   6'h19
`define FEAC_CODE_DS3_LOS  6'h0E
`define FEAC_CODE_DS3_OOF  6'h00
`define FEAC_CODE_DS3_AIS  6'h16
`define FEAC_CODE_DS3_IDLE 6'h1A
`define FEAC_CODE_DS3_NSA  6'h0F
`define FEAC_CODE_COM_NSA  6'h1D
`define FEAC_CODE_MDS1_LOS 6'h15
`define FEAC_CODE_DS1_SA   6'h05
`define FEAC_CODE_SDS1_LOS 6'h1E
`define FEAC_CODE_DS1_NSA  6'h03
`define FEAC_CODE_LOOP_UP  6'h09
`define FEAC_CODE_LOOP_DN  6'h12
`define FEAC_LINE_DS3      6'h1B
`define FEAC_LINE_DS1_BASE 6'h21
`define FEAC_LINE_DS1_ALL  6'h13
`define FEAC_DS1_LINES     5'h1C
`endif

// ---- logic/feac_pkg.sv ----
package feac_pkg;
   typedef enum logic [1:0] {
      BURST_NONE,
      BURST_LOOP_UP,
      BURST_LOOP_DOWN,
      BURST_ALARM
   } burst_type_t;

   // alarm/status selection index; codes outside this set cannot be chosen
   typedef enum logic [3:0] {
      ALM_DS3_SA,
      ALM_DS3_LOS,
      ALM_DS3_OOF,
      ALM_DS3_AIS,
      ALM_DS3_IDLE,
      ALM_DS3_NSA,
      ALM_COM_NSA,
      ALM_MDS1_LOS,
      ALM_DS1_SA,
      ALM_SDS1_LOS,
      ALM_DS1_NSA
   } alarm_sel_t;
endpackage

// ---- logic/feac_code_map.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "feac_consts.svh"
module feac_code_map (
   input  wire logic [3:0] i_alarm_sel,
   input  wire logic [4:0] i_loop_line,
   output logic      [5:0] o_alarm_code,
   output logic      [5:0] o_line_code
);
   function automatic logic [5:0] alarm_code(input logic [3:0] sel);
      case (sel)
         4'h0:    alarm_code = `FEAC_CODE_DS3_SA;   // RULE_11
         4'h1:    alarm_code = `FEAC_CODE_DS3_LOS;  // RULE_11
         4'h2:    alarm_code = `FEAC_CODE_DS3_OOF;  // RULE_11
         4'h3:    alarm_code = `FEAC_CODE_DS3_AIS;  // RULE_12
         4'h4:    alarm_code = `FEAC_CODE_DS3_IDLE; // RULE_12
         4'h5:    alarm_code = `FEAC_CODE_DS3_NSA;  // RULE_12
         4'h6:    alarm_code = `FEAC_CODE_COM_NSA;  // RULE_13
         4'h7:    alarm_code = `FEAC_CODE_MDS1_LOS; // RULE_13
         4'h8:    alarm_code = `FEAC_CODE_DS1_SA;   // RULE_13
         4'h9:    alarm_code = `FEAC_CODE_SDS1_LOS; // RULE_14
         4'hA:    alarm_code = `FEAC_CODE_DS1_NSA;  // RULE_14
         // unassigned selections fall back to a defined code
         default: alarm_code = `FEAC_CODE_DS3_SA;   // RULE_16
      endcase
   endfunction

   // line 0 = DS3, 1..28 = DS1 line n, anything above = all DS1
   function automatic logic [5:0] line_code(input logic [4:0] ln);
      if (ln == 5'h00) begin
         line_code = `FEAC_LINE_DS3; // RULE_17
      end else if (ln <= `FEAC_DS1_LINES) begin
         line_code = `FEAC_LINE_DS1_BASE + {1'b0, ln} - 6'h01; // RULE_17
      end else begin
         line_code = `FEAC_LINE_DS1_ALL; // RULE_17
      end
   endfunction

   assign o_alarm_code = alarm_code(i_alarm_sel);
   assign o_line_code  = line_code(i_loop_line);
endmodule
`default_nettype wire

// ---- logic/feac_shifter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "feac_consts.svh"
module feac_shifter (
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_ce,
   input  wire logic       i_slot,
   input  wire logic       i_load,
   input  wire logic [5:0] i_code,
   output logic            o_bit,
   output logic            o_word_end
);
   logic [15:0] sr_q;
   logic [3:0]  cnt_q;
   logic        bit_q;

   // word = 0xFF flag, 0, code msb first, 0
   wire [15:0] word_w = {`FEAC_FLAG_BYTE, 1'b0, i_code, 1'b0}; // RULE_02 RULE_03
   // count wraps to zero once the sixteenth bit is out
   assign o_word_end = i_slot && (cnt_q == 4'h0);
   assign o_bit      = bit_q;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sr_q  <= 16'h0000;
         cnt_q <= 4'h0;
         bit_q <= 1'b1;
      end else if (i_ce && i_slot) begin
         // one bit per slot, msb first, words back to back
         bit_q <= (i_load ? word_w[15] : sr_q[15]); // RULE_18
         sr_q  <= i_load ? {word_w[14:0], 1'b0} : {sr_q[14:0], 1'b0};
         cnt_q <= i_load ? 4'h1 : cnt_q + 4'h1;
      end
   end

   chk_bit_count: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && i_slot && i_load) |=> (cnt_q == 4'h1)) // RULE_02
      else $error("word bit count not restarted on load");
endmodule
`default_nettype wire

// ---- logic/feac_code_transmitter.sv ----
// How it works
// (RULE_01) codes only inserted under C-bit parity
// (RULE_02) 16-bit word, first byte all ones
// (RULE_03) second byte: zero, code, zero
// (RULE_04) continuous enable sends selected code endlessly
// (RULE_05) burst repeats word 3 to 15 times
// (RULE_06) burst type none sends nothing
// (RULE_07) loop activation sends loop-up code burst
// (RULE_08) loop deactivation sends loop-down code burst
// (RULE_09) alarm burst sends selected alarm code
// (RULE_10) alarm selection feeds continuous and bursts
// (RULE_11) DS3 failure, LOS, OOF codes
// (RULE_12) AIS, idle, DS3 NSA codes
// (RULE_13) common NSA, multi DS1, DS1 SA codes
// (RULE_14) single DS1 LOS, DS1 NSA codes
// (RULE_15) NIU loop up and down codes
// (RULE_16) unassigned codes cannot be selected
// (RULE_17) line identifier codes for DS3/DS1 lines
// (RULE_18) one bit per multiframe, msb first
// (RULE_19) loop burst: command words then line words
// (RULE_20) burst preempts continuous, which then resumes
`timescale 1ns/1ps
`default_nettype none
`include "feac_consts.svh"
module feac_code_transmitter (
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_ce,
   input  wire logic       i_mf_slot,
   input  wire logic       i_parity_framing_format,
   input  wire logic       i_cont_enable,
   input  wire logic [1:0] i_burst_code_type,
   input  wire logic [3:0] i_burst_repeat_count,
   input  wire logic [3:0] i_alarm_sel,
   input  wire logic [4:0] i_loop_line,
   input  wire logic       i_send_trigger,
   output logic            o_feac_bit,
   output logic            o_feac_insert,
   output logic            o_burst_busy
);
   typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_LINE, ST_CONT} state_t;

   state_t     state_q, state_d;
   logic [3:0] reps_q, reps_d, total_q, total_d;
   logic [5:0] cmd_q, cmd_d;
   logic       pend_q, pend_d;
   logic       active_q, active_d;
   logic [5:0] alarm_code, line_code, cur_code;
   logic       word_end, load, shift_bit;

   feac_code_map u_map (
      .i_alarm_sel  (i_alarm_sel),
      .i_loop_line  (i_loop_line),
      .o_alarm_code (alarm_code),
      .o_line_code  (line_code)
   );

   // burst length clamped into the legal 3..15 range
   wire [3:0] reps_w = (i_burst_repeat_count < `FEAC_REP_MIN) ? `FEAC_REP_MIN :
                       i_burst_repeat_count; // RULE_05
   wire type_none = (i_burst_code_type == feac_pkg::BURST_NONE); // RULE_06
   wire [5:0] burst_cmd_w =
      (i_burst_code_type == feac_pkg::BURST_LOOP_UP)   ? `FEAC_CODE_LOOP_UP : // RULE_07 RULE_15
      (i_burst_code_type == feac_pkg::BURST_LOOP_DOWN) ? `FEAC_CODE_LOOP_DN : // RULE_08 RULE_15
      alarm_code; // RULE_09 RULE_10
   wire is_loop_w = (i_burst_code_type == feac_pkg::BURST_LOOP_UP) ||
                    (i_burst_code_type == feac_pkg::BURST_LOOP_DOWN);
   wire line_next = (cmd_q == `FEAC_CODE_LOOP_UP) || (cmd_q == `FEAC_CODE_LOOP_DN);
   // a new word starts on any slot while idle, otherwise only on the slot that ends the word in flight
   wire at_boundary = !active_q || word_end;

   always_comb begin
      state_d  = state_q;
      reps_d   = reps_q;
      total_d  = total_q;
      cmd_d    = cmd_q;
      pend_d   = pend_q;
      active_d = active_q;
      load     = 1'b0;
      cur_code = alarm_code;
      // trigger held until the word in flight finishes, or until the whole burst ends if one is running
      if (i_send_trigger && !type_none && i_parity_framing_format) begin
         pend_d  = 1'b1; // RULE_06
         cmd_d   = burst_cmd_w;
         total_d = reps_w;
      end
      if (!i_parity_framing_format) begin
         state_d  = ST_IDLE; // RULE_01
         active_d = 1'b0;
         pend_d   = 1'b0;
      end else if (i_mf_slot && at_boundary) begin
         case (state_q)
            ST_CMD: begin
               if (reps_q != 4'h0) begin
                  cur_code = cmd_q;
                  load     = 1'b1;
                  reps_d   = reps_q - 4'h1;
               end else if (line_next) begin
                  state_d  = ST_LINE; // RULE_19
                  cur_code = line_code;
                  load     = 1'b1;
                  reps_d   = total_q - 4'h1;
               end else begin
                  state_d = ST_IDLE;
               end
            end
            ST_LINE: begin
               if (reps_q != 4'h0) begin
                  cur_code = line_code; // RULE_19
                  load     = 1'b1;
                  reps_d   = reps_q - 4'h1;
               end else begin
                  state_d = ST_IDLE;
               end
            end
            ST_IDLE, ST_CONT: begin
               state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
         endcase
         if ((state_q == ST_IDLE || state_q == ST_CONT || state_d == ST_IDLE) && !load) begin
            if (pend_q) begin
               state_d  = ST_CMD; // RULE_20
               cur_code = cmd_q; // RULE_05
               load     = 1'b1;
               reps_d   = total_q - 4'h1;
               pend_d   = 1'b0;
            end else if (i_cont_enable) begin
               state_d  = ST_CONT; // RULE_04 RULE_20
               cur_code = alarm_code; // RULE_10
               load     = 1'b1;
            end else begin
               state_d = ST_IDLE;
            end
         end
         active_d = load;
      end
   end

   feac_shifter u_shift (
      .i_clk      (i_clk),
      .i_nrst     (i_nrst),
      .i_ce       (i_ce),
      .i_slot     (i_mf_slot),
      .i_load     (load),
      .i_code     (cur_code),
      .o_bit      (shift_bit),
      .o_word_end (word_end)
   );

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q  <= ST_IDLE;
         reps_q   <= 4'h0;
         total_q  <= `FEAC_REP_MIN;
         cmd_q    <= 6'h00;
         pend_q   <= 1'b0;
         active_q <= 1'b0;
      end else if (i_ce) begin
         state_q  <= state_d;
         reps_q   <= reps_d;
         total_q  <= total_d;
         cmd_q    <= cmd_d;
         pend_q   <= pend_d;
         active_q <= active_d;
      end
   end

   // the C-bit slot keeps its own value when nothing is sent
   assign o_feac_bit    = shift_bit;
   assign o_feac_insert = active_q && i_parity_framing_format; // RULE_01
   assign o_burst_busy  = pend_q || state_q == ST_CMD || state_q == ST_LINE;

   chk_no_insert_m13: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !i_parity_framing_format |-> !o_feac_insert) // RULE_01
      else $error("insert outside C-bit parity");
   chk_none_ignored: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && i_send_trigger && type_none && !pend_q) |=> !pend_q) // RULE_06
      else $error("send with type none was accepted");
   chk_burst_loads: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && state_d == ST_CMD && load) |-> cur_code == cmd_q) // RULE_05
      else $error("burst word not command code");
   chk_line_code: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (state_d == ST_LINE && load) |-> cur_code == line_code) // RULE_19
      else $error("line phase sent wrong code");
   chk_cont_code: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && load && state_d == ST_CONT) |-> cur_code == alarm_code) // RULE_04
      else $error("continuous word not alarm code");
   chk_burst_first: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && pend_q && i_parity_framing_format && i_mf_slot && at_boundary &&
       state_q != ST_CMD && state_q != ST_LINE) |=> state_q == ST_CMD) // RULE_20
      else $error("pending burst did not preempt");
   chk_reps_range: assert property (@(posedge i_clk) disable iff (!i_nrst)
      total_q >= `FEAC_REP_MIN) // RULE_05
      else $error("burst length below minimum");
   chk_loop_cmd: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && i_send_trigger && i_parity_framing_format &&
       i_burst_code_type == feac_pkg::BURST_LOOP_UP) |=> cmd_q == `FEAC_CODE_LOOP_UP) // RULE_07
      else $error("loop up command not latched");
endmodule
`default_nettype wire

// ---- sim/feac_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module feac_far_end (
   input  wire logic i_clk,
   input  wire logic i_mf_slot,
   input  wire logic i_bit,
   input  wire logic i_insert
);
   logic        slot_q;
   logic [15:0] sh_q;
   int          n_q = 0;
   logic [15:0] words[$];
   // one bit per slot; a gap in insert restarts word alignment
   always @(posedge i_clk) begin
      slot_q <= i_mf_slot;
      if (i_insert !== 1'b1) begin
         n_q <= 0;
      end else if (slot_q) begin
         sh_q <= {sh_q[14:0], i_bit};
         n_q <= (n_q == 15) ? 0 : n_q + 1;
         if (n_q == 15) begin
            words.push_back({sh_q[14:0], i_bit});
         end
      end
   end
endmodule
`default_nettype wire

// ---- sim/tb_feac_code_transmitter.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_feac_code_transmitter;
   logic       clk = 1'b0;
   logic       nrst = 1'b0;
   logic       slot = 1'b0;
   logic       parity_framing_format = 1'b1;
   logic       cont = 1'b0;
   logic [1:0] btype = 2'h0;
   logic [3:0] bcnt = 4'h3;
   logic [3:0] asel = 4'h0;
   logic [4:0] line = 5'h00;
   logic       trig = 1'b0;
   logic       fbit;
   logic       fins;
   logic       busy;
   int         n_mismatch = 0;
   int         checked = 0;
   int         slot_cnt = 0;
   logic [5:0] codes [11] = '{6'h19, 6'h0E, 6'h00, 6'h16, 6'h1A, 6'h0F,
                              6'h1D, 6'h15, 6'h05, 6'h1E, 6'h03};

   feac_code_transmitter feac_code_transmitter_i (
      .i_clk                   (clk),
      .i_nrst                  (nrst),
      .i_ce                    (1'b1),
      .i_mf_slot               (slot),
      .i_parity_framing_format (parity_framing_format),
      .i_cont_enable           (cont),
      .i_burst_code_type       (btype),
      .i_burst_repeat_count    (bcnt),
      .i_alarm_sel             (asel),
      .i_loop_line             (line),
      .i_send_trigger          (trig),
      .o_feac_bit              (fbit),
      .o_feac_insert           (fins),
      .o_burst_busy            (busy)
   );

   feac_far_end feac_far_end_i (
      .i_clk    (clk),
      .i_mf_slot(slot),
      .i_bit    (fbit),
      .i_insert (fins)
   );

   always #2.5 clk = ~clk;

   // short multiframe keeps bursts cheap to simulate
   always @(negedge clk) begin
      slot_cnt <= (slot_cnt + 1) % 4;
      slot <= (slot_cnt == 3);
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic burst(input logic [1:0] t, input logic [3:0] c,
                        input logic [3:0] s, input logic [4:0] l);
      btype = t;
      bcnt = c;
      asel = s;
      line = l;
      feac_far_end_i.words.delete();
      trig = 1'b1;
      tick(1);
      trig = 1'b0;
      check({15'h0, busy}, {15'h0, (t != 2'h0) && parity_framing_format});
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) tick(1);
      for (int i = 0; i < 100 && fins !== 1'b0; i++) tick(1);
   endtask

   task automatic expect_words(input int n, input logic [5:0] a,
                               input logic [5:0] b, input int nb);
      check(16'(feac_far_end_i.words.size()), 16'(n + nb));
      foreach (feac_far_end_i.words[i]) begin
         check(feac_far_end_i.words[i], {8'hFF, 1'b0, (i < n) ? a : b, 1'b0});
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      tick(20);
      check({13'h0, fbit, fins, busy}, 16'h0004);
      nrst = 1'b1;
      tick(4);
      parity_framing_format = 1'b0;
      burst(2'h3, 4'h3, 4'h0, 5'h00);
      expect_words(0, 6'h00, 6'h00, 0);
      parity_framing_format = 1'b1;
      burst(2'h0, 4'h3, 4'h0, 5'h00);
      expect_words(0, 6'h00, 6'h00, 0);
      for (int s = 0; s < 16; s++) begin
         burst(2'h3, 4'h3, 4'(s), 5'h00);
         expect_words(3, (s < 11) ? codes[s] : codes[0], 6'h00, 0);
      end
      burst(2'h1, 4'hF, 4'h0, 5'h1C);
      expect_words(15, 6'h09, 6'h3C, 15);
      burst(2'h2, 4'h4, 4'h0, 5'h00);
      expect_words(4, 6'h12, 6'h1B, 4);
      // continuous AIS, then a loop burst cuts in between words
      cont = 1'b1;
      asel = 4'h3;
      tick(200);
      burst(2'h1, 4'h3, 4'h3, 5'h1D);
      tick(140);
      while (feac_far_end_i.words.size() > 0 && feac_far_end_i.words[0] === 16'hFF2C)
         void'(feac_far_end_i.words.pop_front());
      check(feac_far_end_i.words[6], 16'hFF2C);
      feac_far_end_i.words = feac_far_end_i.words[0:5];
      expect_words(3, 6'h09, 6'h13, 3);
      test_done();
   end

   initial begin
      #200us;
      n_mismatch++;
      test_done();
   end
endmodule
`default_nettype wire
